// ===== logic/mfrs_pkg.sv
// Notes on behaviour
// RULE1 - Every unit abort or trap vectors through kernel virtual location 250.
// RULE2 - Any abort flag set freezes status bits 7-1 and the change and PC records.
// RULE3 - Error flags update only while relocation is active (enable, or maint+final dest).
// RULE4 - Software writes land only in error-flag, relocation-enable, maintenance and trap-enable bits.
// RULE5 - Software-set error flags raise no trap; software clears them after each fault.
// RULE6 - Non-resident abort on access key 0, 3 or 7, or illegal mode 2.
// RULE7 - Page-length abort when block number lies outside the page length field.
// RULE8 - Read-only abort on a write to a page with access key 1 or 2.
// RULE9 - Management trap on read with key 1 or 4, or write with key 4 or 5.
// RULE10 - Status bits 11 and 10 always read zero.
// RULE11 - Trap-enable clear takes no trap; when set the next potential trap is taken.
// RULE12 - A potential trap before the status write still traps at instruction end.
// RULE13 - Instruction-completed bit read-only, resets to one, cleared on hardware traps.
// RULE14 - Mode bits 6-5 record kernel 00, supervisor 01, user 11; 10 aborts.
// RULE15 - Bit 4 records space, bits 3-1 the faulting page number.
// RULE16 - Relocation-enable one relocates every address; zero leaves the unit inoperative; the code still checks final-dest references when maint is set.
// RULE17 - Change record clears on fetch; auto-inc/dec logs register mod 8 and amount.
// RULE18 - Two change entries, low byte first: amount above three-bit register number.
// RULE19 - Virtual PC takes fetch address, or trap vector on hardware traps only.
// RULE20 - Data-space enable bits 0,1,2 for user, supervisor, kernel; resets to zero.
// RULE21 - After flags clear, the next reference resumes normal status updating.
// RULE22 - Initialize clears flags and control bits, instruction-completed stays one.
package mfrs_pkg;
    localparam logic [15:0] MFRS_FAULT_VECTOR = 16'h00A8;
    localparam int          MFRS_ABT_NR       = 15;
    localparam int          MFRS_ABT_LEN      = 14;
    localparam int          MFRS_ABT_RO       = 13;
    localparam int          MFRS_TRP_MM       = 12;
    localparam int          MFRS_TRAP_EN      = 9;
    localparam int          MFRS_MAINT        = 8;
    localparam int          MFRS_INSTR_DONE   = 7;
    localparam int          MFRS_RELOCATION_ACTIVE_EN     = 0;
    localparam logic [1:0]  MFRS_MODE_ILLEGAL = 2'h2;
    localparam logic [2:0]  MFRS_DSE_MASK     = 3'h7;
    localparam logic [1:0]  MFRS_REG_FSC      = 2'h0;
    localparam logic [1:0]  MFRS_REG_RCR      = 2'h1;
    localparam logic [1:0]  MFRS_REG_VPC      = 2'h2;
    localparam logic [1:0]  MFRS_REG_DSE      = 2'h3;

    typedef enum logic [2:0] {
        MFRS_KEY_NONRES = 3'h0, MFRS_KEY_RO_TRAP = 3'h1, MFRS_KEY_RO = 3'h2,
        MFRS_KEY_RSV3   = 3'h3, MFRS_KEY_RW_TRAP = 3'h4, MFRS_KEY_RW_WTRAP = 3'h5,
        MFRS_KEY_RW     = 3'h6, MFRS_KEY_RSV7    = 3'h7
    } mfrs_key_type;

    // One memory reference as presented by the core
    typedef struct packed {
        logic         valid;
        logic         write;
        logic         dspace;
        logic         final_dest;
        logic [1:0]   mode;
        logic [15:0]  vaddr;
        mfrs_key_type key;
        logic [6:0]   page_len;
        logic         expand_down;
    } mfrs_ref_type;

    // Register change event from the core
    typedef struct packed {
        logic       valid;
        logic [2:0] regnum;
        logic [4:0] amount;
    } mfrs_chg_type;
endpackage

// ===== logic/mfrs_access_check.sv
`timescale 1ns/10ps
module mfrs_access_check
    import mfrs_pkg::*;
(
    // Reference in
    input  wire mfrs_ref_type ref_in,
    // Fault classes out
    output logic [3:0]        flags_out
);
    logic [6:0] blk;
    logic       len_err;
    always_comb begin
        blk     = ref_in.vaddr[12:6];
        len_err = ref_in.expand_down ? (blk < ref_in.page_len)
                                     : (blk > ref_in.page_len); // RULE7
        flags_out[3] = (ref_in.key == MFRS_KEY_NONRES)
                     || (ref_in.key == MFRS_KEY_RSV3)
                     || (ref_in.key == MFRS_KEY_RSV7)
                     || (ref_in.mode == MFRS_MODE_ILLEGAL); // RULE6 RULE14
        flags_out[2] = len_err;
        flags_out[1] = ref_in.write && ((ref_in.key == MFRS_KEY_RO_TRAP)
                     || (ref_in.key == MFRS_KEY_RO)); // RULE8
        flags_out[0] = ref_in.write
            ? ((ref_in.key == MFRS_KEY_RW_TRAP)
               || (ref_in.key == MFRS_KEY_RW_WTRAP))
            : ((ref_in.key == MFRS_KEY_RO_TRAP)
               || (ref_in.key == MFRS_KEY_RW_TRAP)); // RULE9
    end
endmodule // mfrs_access_check

// ===== logic/mfrs_change_log.sv
`timescale 1ns/10ps
module mfrs_change_log
    import mfrs_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    // Control
    input  wire logic         clear_in,
    input  wire logic         freeze_in,
    input  wire mfrs_chg_type chg_in,
    // Record
    output logic [15:0]       record_out
);
    logic [15:0] rec_r, rec_nxt;
    logic        hi_r, hi_nxt;
    always_comb begin
        rec_nxt = rec_r;
        hi_nxt  = hi_r;
        if (freeze_in) begin
            rec_nxt = rec_r; // RULE2
        end else if (clear_in) begin
            rec_nxt = 16'h0000; // RULE17
            hi_nxt  = 1'b0;
        end else if (chg_in.valid) begin
            if (!hi_r) begin
                rec_nxt[7:0] = {chg_in.amount, chg_in.regnum}; // RULE18
                hi_nxt       = 1'b1;
            end else begin
                rec_nxt[15:8] = {chg_in.amount, chg_in.regnum}; // RULE18
            end
        end
    end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rec_r <= 16'h0000;
            hi_r  <= 1'b0;
        end else begin
            rec_r <= rec_nxt;
            hi_r  <= hi_nxt;
        end
    end
    assign record_out = rec_r;

    chg_low_first_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !freeze_in && !clear_in && chg_in.valid && !hi_r |=>
        rec_r[7:0] == $past({chg_in.amount, chg_in.regnum}))
        else $error("first change not in low byte"); // RULE18
    chg_clear_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !freeze_in && clear_in |=> rec_r == 16'h0000)
        else $error("change record not cleared on fetch"); // RULE17
endmodule // mfrs_change_log

// ===== logic/mfrs_status.sv
`timescale 1ns/10ps
module mfrs_status
    import mfrs_pkg::*;
(
    // Clock and reset
    input  wire logic         sys_clk_in,
    input  wire logic         rst_in,
    // Core events
    input  wire mfrs_ref_type ref_in,
    input  wire logic         fetch_in,
    input  wire logic         hw_trap_in,
    input  wire logic [15:0]  hw_vector_in,
    input  wire logic         instr_end_in,
    input  wire mfrs_chg_type chg_in,
    // Register access
    input  wire logic [1:0]   reg_sel_in,
    input  wire logic         reg_wr_in,
    input  wire logic [15:0]  reg_wdata_in,
    output logic [15:0]       reg_rdata_out,
    // Results to core
    output logic              abort_out,
    output logic              mm_trap_out,
    output logic [15:0]       vector_out,
    output logic              relocation_active_en_out,
    output logic              relocation_active_active_out,
    output logic [2:0]        dspace_en_out
);
    logic [3:0]  flags_r, flags_nxt;
    logic        trap_en_r, trap_en_nxt;
    logic        maint_r, maint_nxt;
    logic        relocation_active_r, relocation_active_nxt;
    logic        done_r, done_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic        space_r, space_nxt;
    logic [2:0]  page_r, page_nxt;
    logic [15:0] vpc_r, vpc_nxt;
    logic [2:0]  dse_r, dse_nxt;
    logic        pend_r, pend_nxt;
    logic        abort_r, abort_nxt;
    logic        trap_r, trap_nxt;
    logic [3:0]  hit;
    logic        relocation_active_act, freeze, fsc_wr;
    logic [15:0] fsc_val, rcr_val;
    logic        ref_take;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    mfrs_access_check u_check (
        .ref_in    (ref_in),
        .flags_out (hit)
    );

    assign freeze = |flags_r[3:1]; // RULE2

    mfrs_change_log u_log (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .clear_in   (fetch_in),
        .freeze_in  (freeze),
        .chg_in     (chg_in),
        .record_out (rcr_val)
    );

    always_comb begin
        relocation_active_act = relocation_active_r || (maint_r && ref_in.final_dest); // RULE3 RULE16
        fsc_wr    = reg_wr_in && (reg_sel_in == MFRS_REG_FSC);
        flags_nxt   = flags_r;
        trap_en_nxt = trap_en_r;
        maint_nxt   = maint_r;
        relocation_active_nxt   = relocation_active_r;
        done_nxt    = done_r;
        mode_nxt    = mode_r;
        space_nxt   = space_r;
        page_nxt    = page_r;
        vpc_nxt     = vpc_r;
        dse_nxt     = dse_r;
        pend_nxt    = pend_r;
        abort_nxt   = 1'b0;
        trap_nxt    = 1'b0;
        if (fsc_wr) begin
            // Software may write flag bits but that never raises a trap
            flags_nxt   = reg_wdata_in[MFRS_ABT_NR:MFRS_TRP_MM]; // RULE5
            trap_en_nxt = reg_wdata_in[MFRS_TRAP_EN]; // RULE4
            maint_nxt   = reg_wdata_in[MFRS_MAINT]; // RULE4
            relocation_active_nxt   = reg_wdata_in[MFRS_RELOCATION_ACTIVE_EN]; // RULE4
        end
        if (reg_wr_in && (reg_sel_in == MFRS_REG_DSE)) begin
            dse_nxt = reg_wdata_in[2:0] & MFRS_DSE_MASK; // RULE20
        end
        // Hardware events win over a same-cycle software write
        if (ref_in.valid && relocation_active_act && (flags_r == 4'h0)) begin // RULE21
            if (|hit[3:1]) begin
                flags_nxt = hit; // RULE3
                abort_nxt = 1'b1; // RULE1
            end else if (hit[0]) begin
                flags_nxt[0] = 1'b1; // RULE9
                // Latch the potential trap against the enable seen now
                if (trap_en_r) begin
                    pend_nxt = 1'b1; // RULE11 RULE12
                end
            end
            if (|hit) begin
                mode_nxt  = ref_in.mode; // RULE14
                space_nxt = ref_in.dspace; // RULE15
                page_nxt  = ref_in.vaddr[15:13]; // RULE15
            end
        end
        if (!freeze) begin
            if (fetch_in) begin
                vpc_nxt  = ref_in.vaddr; // RULE19
                done_nxt = 1'b1;
            end
            if (hw_trap_in) begin
                vpc_nxt  = hw_vector_in; // RULE19
                done_nxt = 1'b0; // RULE13
            end
        end
        if (instr_end_in && (pend_r || pend_nxt)) begin
            trap_nxt = 1'b1; // RULE12
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            flags_r   <= 4'h0; // RULE22
            trap_en_r <= 1'b0;
            maint_r   <= 1'b0;
            relocation_active_r   <= 1'b0;
            done_r    <= 1'b1; // RULE13
            mode_r    <= 2'h0;
            space_r   <= 1'b0;
            page_r    <= 3'h0;
            vpc_r     <= 16'h0000;
            dse_r     <= 3'h0; // RULE20
            pend_r    <= 1'b0;
            abort_r   <= 1'b0;
            trap_r    <= 1'b0;
        end else begin
            flags_r   <= flags_nxt;
            trap_en_r <= trap_en_nxt;
            maint_r   <= maint_nxt;
            relocation_active_r   <= relocation_active_nxt;
            done_r    <= done_nxt;
            mode_r    <= mode_nxt;
            space_r   <= space_nxt;
            page_r    <= page_nxt;
            vpc_r     <= vpc_nxt;
            dse_r     <= dse_nxt;
            pend_r    <= pend_nxt;
            abort_r   <= abort_nxt;
            trap_r    <= trap_nxt;
        end
    end

    always_comb begin
        fsc_val = {flags_r, 2'h0, trap_en_r, maint_r, done_r, mode_r,
                   space_r, page_r, relocation_active_r}; // RULE10
        case (reg_sel_in)
            MFRS_REG_FSC: reg_rdata_out = fsc_val;
            MFRS_REG_RCR: reg_rdata_out = rcr_val;
            MFRS_REG_VPC: reg_rdata_out = vpc_r;
            MFRS_REG_DSE: reg_rdata_out = {13'h0000, dse_r};
            default:      reg_rdata_out = 16'h0000;
        endcase
    end

    assign abort_out        = abort_r;
    assign mm_trap_out      = trap_r;
    assign vector_out       = MFRS_FAULT_VECTOR; // RULE1
    assign relocation_active_en_out     = relocation_active_r; // RULE16
    assign relocation_active_active_out = relocation_active_act;
    assign dspace_en_out    = dse_r;

    freeze_vpc_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        freeze |=> $stable(vpc_r))
        else $error("virtual pc moved while frozen"); // RULE2
    nonres_abort_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ref_in.valid && relocation_active_act && flags_r == 4'h0 && hit[3]
        |=> flags_r[3] && abort_r)
        else $error("non-resident abort missing"); // RULE6
    no_relocation_active_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !relocation_active_act && !fsc_wr && ref_in.valid |=> $stable(flags_r))
        else $error("flags changed without relocation"); // RULE3
    spare_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        reg_sel_in == MFRS_REG_FSC |-> reg_rdata_out[11:10] == 2'h0)
        else $error("spare bits not zero"); // RULE10
    sw_no_trap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        fsc_wr && !ref_in.valid && !pend_r |=> !trap_r)
        else $error("software write raised trap"); // RULE5
    trap_disabled_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !trap_en_r && !pend_r |=> !pend_r)
        else $error("trap pending while disabled"); // RULE11
    hw_vector_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        hw_trap_in && !freeze |=> vpc_r == $past(hw_vector_in) && !done_r)
        else $error("hardware trap not captured"); // RULE19
    pend_trap_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        pend_r && instr_end_in |=> trap_r ##1 !trap_r)
        else $error("pending trap not taken"); // RULE12
    mode_rec_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ref_in.valid && relocation_active_act && flags_r == 4'h0 && |hit
        |=> mode_r == $past(ref_in.mode) && page_r == $past(ref_in.vaddr[15:13]))
        else $error("fault context not recorded"); // RULE14

    abort_seen_c: cover property (@(posedge sys_clk_in) abort_r);
    trap_seen_c:  cover property (@(posedge sys_clk_in) trap_r);
    freeze_c:     cover property (@(posedge sys_clk_in) freeze ##1 !freeze);
    hw_trap_c:    cover property (@(posedge sys_clk_in) hw_trap_in);
    fetch_c:      cover property (@(posedge sys_clk_in) fetch_in && !freeze);

    // A reference that the flags gate lets through
    assign ref_take = ref_in.valid && relocation_active_act && (flags_r == 4'h0);

    // Abort side
    abort_flags_a: assert property (
        abort_r |-> flags_r[3:1] != 3'h0)
        else $error("abort without abort flag"); // RULE2
    abort_pulse_a: assert property (
        abort_r |=> !abort_r)
        else $error("abort longer than one cycle"); // RULE1
    ro_key2_a: assert property (
        ref_take && ref_in.write && ref_in.key == MFRS_KEY_RO
        |=> flags_r[1] && abort_r)
        else $error("read-only abort missing"); // RULE8
    ro_key1_a: assert property (
        ref_take && ref_in.write && ref_in.key == MFRS_KEY_RO_TRAP
        |=> flags_r[1] && abort_r)
        else $error("read-only trap key abort missing"); // RULE8
    len_up_a: assert property (
        ref_take && !ref_in.expand_down
        && ref_in.vaddr[12:6] > ref_in.page_len |=> flags_r[2])
        else $error("page length abort missing"); // RULE7
    mode_bad_a: assert property (
        ref_take && ref_in.mode == MFRS_MODE_ILLEGAL
        |=> flags_r[3] && abort_r)
        else $error("illegal mode not aborted"); // RULE14
    ctx_space_a: assert property (
        ref_take && |hit
        |=> space_r == $past(ref_in.dspace))
        else $error("fault space not recorded"); // RULE15

    // Trap side
    trap_flag_a: assert property (
        ref_take && !ref_in.write && ref_in.key == MFRS_KEY_RW_TRAP
        && hit[3:1] == 3'h0 |=> flags_r[0] && !abort_r)
        else $error("management trap flag missing"); // RULE9
    trap_off_a: assert property (
        !trap_en_r && !pend_r
        |=> !trap_r)
        else $error("trap taken while disabled"); // RULE11

    // Freeze and resume
    freeze_ctx_a: assert property (
        freeze
        |=> $stable({mode_r, space_r, page_r, done_r}))
        else $error("status bits moved while frozen"); // RULE2
    freeze_rcr_a: assert property (
        freeze
        |=> $stable(rcr_val))
        else $error("change record moved while frozen"); // RULE2
    hold_flags_a: assert property (
        flags_r != 4'h0 && !fsc_wr
        |=> $stable(flags_r))
        else $error("flags moved before software clear"); // RULE21
    clear_flags_a: assert property (
        fsc_wr && reg_wdata_in[15:12] == 4'h0 && !ref_in.valid
        |=> flags_r == 4'h0)
        else $error("flags not cleared by software"); // RULE5

    // Records
    fetch_vpc_a: assert property (
        fetch_in && !hw_trap_in && !freeze
        |=> vpc_r == $past(ref_in.vaddr) && done_r)
        else $error("fetch address not captured"); // RULE19
    rcr_fetch_a: assert property (
        fetch_in && !freeze
        |=> rcr_val == 16'h0000)
        else $error("change record kept across fetch"); // RULE17
    vpc_ro_a: assert property (
        !fetch_in && !hw_trap_in
        |=> $stable(vpc_r))
        else $error("virtual pc moved without event"); // RULE19
    done_ro_a: assert property (
        !fetch_in && !hw_trap_in
        |=> $stable(done_r))
        else $error("completed bit moved by software"); // RULE13

    // Software controls
    fsc_ctrl_a: assert property (
        fsc_wr
        |=> trap_en_r == $past(reg_wdata_in[MFRS_TRAP_EN]))
        else $error("trap enable not written"); // RULE4
    fsc_relocation_active_a: assert property (
        fsc_wr
        |=> relocation_active_r == $past(reg_wdata_in[MFRS_RELOCATION_ACTIVE_EN]))
        else $error("relocation enable not written"); // RULE16
    dse_write_a: assert property (
        reg_wr_in && reg_sel_in == MFRS_REG_DSE
        |=> dse_r == $past(reg_wdata_in[2:0]))
        else $error("data space enable not written"); // RULE20
endmodule // mfrs_status

// ===== verif/mfrs_core_model.sv
`timescale 1ns/10ps
module mfrs_core_model
    import mfrs_pkg::*;
(
    // Clock
    input  wire logic    sys_clk_in,
    // Core events
    output mfrs_ref_type ref_out,
    output logic         fetch_out,
    output logic         hw_trap_out,
    output logic [15:0]  hw_vector_out,
    output logic         instr_end_out,
    output mfrs_chg_type chg_out
);
    initial begin
        ref_out = '0;
        fetch_out = 1'b0;
        hw_trap_out = 1'b0;
        hw_vector_out = 16'h0000;
        instr_end_out = 1'b0;
        chg_out = '0;
    end

    task automatic step();
        @(posedge sys_clk_in);
        #1;
    endtask

    // Fetches carry their address on the reference in the same cycle
    task automatic access(input logic f, w, d, fin, input logic [1:0] md,
                          input logic [15:0] va, input logic [2:0] k,
                          input logic [6:0] pl, input logic ed);
        ref_out = '{1'b1, w, d, fin, md, va, mfrs_key_type'(k), pl, ed};
        fetch_out = f;
        step();
        // Released lines must not keep looking like the last reference
        ref_out = ~ref_out;
        ref_out.valid = 1'b0;
        fetch_out = 1'b0;
    endtask

    task automatic change(input logic [2:0] r, input logic [4:0] a);
        chg_out = '{1'b1, r, a};
        step();
        chg_out = ~chg_out;
        chg_out.valid = 1'b0;
    endtask

    task automatic end_instr();
        instr_end_out = 1'b1;
        step();
        instr_end_out = 1'b0;
    endtask

    // Only hardware traps come here; software traps never pulse the line
    task automatic hw_trap(input logic [15:0] v);
        hw_vector_out = v;
        hw_trap_out = 1'b1;
        step();
        hw_trap_out = 1'b0;
        hw_vector_out = ~v;
    endtask
endmodule // mfrs_core_model

// ===== verif/mfrs_status_tb.sv
`timescale 1ns/10ps
module mmu_fault_recovery_status_tb
    import mfrs_pkg::*;
;
    logic         sys_clk_in = 1'b0;
    logic         rst_in = 1'b1;
    mfrs_ref_type ref_w;
    mfrs_chg_type chg_w;
    logic         fetch_w, hwt_w, iend_w, reg_wr, abort_w, trap_w;
    logic         ren_w, ract_w;
    logic [15:0]  hwv_w, reg_wdata, rdata_w, vec_w;
    logic [1:0]   reg_sel = 2'h0;
    logic [2:0]   dse_w;
    int           fails = 0;
    int           samples_checked = 0;

    always #5 sys_clk_in = ~sys_clk_in;
    initial reg_wr = 1'b0;
    initial reg_wdata = 16'h0000;

    mfrs_core_model core_u (.sys_clk_in(sys_clk_in), .ref_out(ref_w),
        .fetch_out(fetch_w), .hw_trap_out(hwt_w), .hw_vector_out(hwv_w),
        .instr_end_out(iend_w), .chg_out(chg_w));

    mfrs_status dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .ref_in(ref_w), .fetch_in(fetch_w), .hw_trap_in(hwt_w),
        .hw_vector_in(hwv_w), .instr_end_in(iend_w), .chg_in(chg_w),
        .reg_sel_in(reg_sel), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata_w), .abort_out(abort_w), .mm_trap_out(trap_w),
        .vector_out(vec_w), .relocation_active_en_out(ren_w),
        .relocation_active_active_out(ract_w), .dspace_en_out(dse_w));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [1:0] s, input logic [15:0] m, e);
        reg_sel = s;
        #1;
        chk(rdata_w & m, e);
    endtask

    task automatic wr(input logic [1:0] s, input logic [15:0] d);
        reg_sel = s;
        reg_wr = 1'b1;
        reg_wdata = d;
        core_u.step();
        reg_wr = 1'b0;
    endtask

    task automatic fetch(input logic [15:0] va);
        core_u.access(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, va, 3'h6, 7'h7F, 1'b0);
    endtask

    task automatic t_case(input logic w, input logic [1:0] md,
                          input logic [2:0] k, input logic [15:0] va,
                          input logic [6:0] pl, input logic ed,
                          input logic [3:0] fl);
        wr(MFRS_REG_FSC, 16'h0001);
        core_u.access(1'b0, w, ~w, 1'b0, md, va, k, pl, ed);
        chk({15'h0, abort_w}, {15'h0, |fl[3:1]});
        rd(MFRS_REG_FSC, 16'hF000, {fl, 12'h000});
        if (|fl[3:1] && md != MFRS_MODE_ILLEGAL)
            rd(MFRS_REG_FSC, 16'hFFFF, {fl, 12'h081} | {9'h0, md, ~w,
               va[15:13], 1'b0});
    endtask

    task automatic t_basic();
        rd(MFRS_REG_FSC, 16'hFFFF, 16'h0080);
        rd(MFRS_REG_DSE, 16'hFFFF, 16'h0000);
        chk(vec_w, 16'h00A8);
        wr(MFRS_REG_DSE, 16'h0005);
        chk({13'h0, dse_w}, 16'h0005);
        wr(MFRS_REG_RCR, 16'hFFFF);
        wr(MFRS_REG_VPC, 16'hFFFF);
        rd(MFRS_REG_RCR, 16'hFFFF, 16'h0000);
        rd(MFRS_REG_VPC, 16'hFFFF, 16'h0000);
        wr(MFRS_REG_FSC, 16'hFFFF);
        rd(MFRS_REG_FSC, 16'hFFFF, 16'hF381);
        core_u.end_instr();
        chk({15'h0, trap_w}, 16'h0000);
        wr(MFRS_REG_FSC, 16'h0001);
        chk({15'h0, ren_w}, 16'h0001);
        chk({15'h0, ract_w}, 16'h0001);
        $display("test basic done");
    endtask

    task automatic t_record();
        fetch(16'h1234);
        rd(MFRS_REG_VPC, 16'hFFFF, 16'h1234);
        core_u.change(3'h2, 5'h02);
        core_u.change(3'h7, 5'h1E);
        rd(MFRS_REG_RCR, 16'hFFFF, 16'hF712);
        fetch(16'h0400);
        rd(MFRS_REG_RCR, 16'hFFFF, 16'h0000);
        core_u.change(3'h3, 5'h01);
        core_u.access(1'b0, 1'b0, 1'b1, 1'b0, 2'h3, 16'hA000, 3'h0, 7'h7F, 1'b0);
        fetch(16'h0800);
        core_u.change(3'h4, 5'h02);
        rd(MFRS_REG_RCR, 16'hFFFF, 16'h000B);
        rd(MFRS_REG_VPC, 16'hFFFF, 16'h0400);
        wr(MFRS_REG_FSC, 16'h0001);
        fetch(16'h0C00);
        rd(MFRS_REG_VPC, 16'hFFFF, 16'h0C00);
        $display("test record done");
    endtask

    task automatic t_faults();
        t_case(1'b0, 2'h3, 3'h0, 16'hA000, 7'h7F, 1'b0, 4'h8);
        t_case(1'b1, 2'h1, 3'h3, 16'h4000, 7'h7F, 1'b0, 4'h8);
        t_case(1'b0, 2'h0, 3'h7, 16'hE000, 7'h7F, 1'b0, 4'h8);
        t_case(1'b0, 2'h2, 3'h6, 16'h2000, 7'h7F, 1'b0, 4'h8);
        t_case(1'b0, 2'h1, 3'h6, 16'h6100, 7'h03, 1'b0, 4'h4);
        t_case(1'b1, 2'h3, 3'h6, 16'h6080, 7'h03, 1'b1, 4'h4);
        t_case(1'b0, 2'h0, 3'h0, 16'h6100, 7'h03, 1'b0, 4'hC);
        t_case(1'b1, 2'h3, 3'h1, 16'h8000, 7'h7F, 1'b0, 4'h2);
        t_case(1'b1, 2'h1, 3'h2, 16'hC000, 7'h7F, 1'b0, 4'h2);
        t_case(1'b0, 2'h3, 3'h1, 16'h8000, 7'h7F, 1'b0, 4'h1);
        t_case(1'b0, 2'h3, 3'h4, 16'h8000, 7'h7F, 1'b0, 4'h1);
        t_case(1'b1, 2'h3, 3'h4, 16'h8000, 7'h7F, 1'b0, 4'h1);
        t_case(1'b1, 2'h3, 3'h5, 16'h8000, 7'h7F, 1'b0, 4'h1);
        t_case(1'b0, 2'h3, 3'h5, 16'h8000, 7'h7F, 1'b0, 4'h0);
        $display("test faults done");
    endtask

    task automatic t_control();
        wr(MFRS_REG_FSC, 16'h0000);
        core_u.access(1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 16'h0000, 3'h0, 7'h7F, 1'b0);
        chk({15'h0, abort_w}, 16'h0000);
        wr(MFRS_REG_FSC, 16'h0100);
        core_u.access(1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 16'h0000, 3'h0, 7'h7F, 1'b0);
        chk({15'h0, abort_w}, 16'h0001);
        wr(MFRS_REG_FSC, 16'h0201);
        core_u.access(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 3'h4, 7'h7F, 1'b0);
        core_u.end_instr();
        chk({15'h0, trap_w}, 16'h0001);
        wr(MFRS_REG_FSC, 16'h0201);
        core_u.access(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 3'h4, 7'h7F, 1'b0);
        wr(MFRS_REG_FSC, 16'h0001);
        core_u.end_instr();
        chk({15'h0, trap_w}, 16'h0001);
        wr(MFRS_REG_FSC, 16'h0001);
        core_u.access(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 3'h4, 7'h7F, 1'b0);
        core_u.end_instr();
        chk({15'h0, trap_w}, 16'h0000);
        wr(MFRS_REG_FSC, 16'h0001);
        core_u.hw_trap(16'h0004);
        rd(MFRS_REG_VPC, 16'hFFFF, 16'h0004);
        rd(MFRS_REG_FSC, 16'h0080, 16'h0000);
        $display("test control done");
    endtask

    task automatic report_and_stop();
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Whole run is about seventy cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge sys_clk_in);
        #1;
        rst_in = 1'b0;
        t_basic();
        t_record();
        t_faults();
        t_control();
        report_and_stop();
    end
endmodule // mmu_fault_recovery_status_tb
